// ### ads_diagnostic_result_select.sv
`timescale 1ns/1ps

module ads_diagnostic_result_select (
   input  wire logic             ref_clk,
   input  wire logic             resetn,
   input  wire ads_pkg::ads_cfg_t  cfg,
   input  wire logic             acq_start,
   input  wire logic             diagnostic_result_phase,
   input  wire logic             acq_done,
   input  wire ads_pkg::ads_conv_t conv,
   input  wire logic             die_temp_over,
   output ads_pkg::ads_ana_t     ana,
   output logic [15:0]           diagnostic_result,
   output logic                  die_overtemp_alert,
   output logic                  result_ready,
   output logic                  test_path_active
);
   import ads_pkg::*;

   // =========================================================
   // state
   typedef struct packed {
      ads_state_t  state;
      logic [2:0]  sel;
      logic        test;
      ads_ana_t    ana;
      logic [13:0] stage;
      logic        stage_ok;
      logic        stage_alert;
      logic [15:0] result;
      logic        alert;
      logic        done;
      logic        test_act;
   } ads_reg_t;

   ads_reg_t r_q;
   ads_reg_t r_d;
   logic     active;
   logic     in_diagnostic_result;

   // codes 0 and 7 never count as a diagnostic
   function automatic logic sel_valid(input logic [2:0] s);
      sel_valid = (s != SEL_NONE) && (s != SEL_RSVD);
   endfunction : sel_valid

   assign in_diagnostic_result = (r_q.state == ST_ACQ) && diagnostic_result_phase;
   assign active  = in_diagnostic_result && sel_valid(r_q.sel);

   // =========================================================
   // next state
   always_comb begin
      r_d      = r_q;
      r_d.done = 1'b0;
      case (r_q.state)
         ST_IDLE: begin
            // select code is frozen for the whole acquisition so a
            // host write mid-scan cannot split a diagnostic
            if (acq_start) begin
               r_d.state    = ST_ACQ;
               r_d.sel      = cfg.sel;
               r_d.test     = cfg.adc_test;
               r_d.stage_ok = 1'b0;
            end
         end
         ST_ACQ: begin
            if (acq_done) begin
               r_d.state = ST_IDLE;
               r_d.done  = 1'b1;
               if (r_q.stage_ok) begin
                  r_d.result = {r_q.stage, RES_PAD};
                  if (r_q.sel == SEL_TEMP && !r_q.test) begin
                     r_d.alert = r_q.stage_alert;
                  end
               end
            end
         end
         default: begin
            r_d.state = ST_IDLE;
         end
      endcase

      // capture the diagnostic conversion; bipolar coding of a zero
      // input as mid-scale is the converter's own, passed untouched
      if (in_diagnostic_result && conv.valid && (sel_valid(r_q.sel) || r_q.test)) begin
         r_d.stage    = r_q.test ? TEST_CODE : conv.code;
         r_d.stage_ok = 1'b1;
         if (r_q.sel == SEL_TEMP) begin
            r_d.stage_alert = die_temp_over;
         end
      end

      // analog path steering, only inside the diagnostic portion
      r_d.ana.src       = active ? r_q.sel : SEL_NONE;
      r_d.ana.ref_thrm  = active && (r_q.sel == SEL_SUPPLY);
      r_d.ana.amp_short = active && (r_q.sel == SEL_AMP);
      // outside the portion the host settings pass straight through
      r_d.ana.bipolar   = (active && (r_q.sel == SEL_AMP ||
                           r_q.sel == SEL_ZERO ||
                           r_q.sel == SEL_FULL))
                          ? 1'b1 : cfg.host_bipolar;
      r_d.ana.chop      = (active && r_q.sel == SEL_AMP)
                          ? 1'b0 : cfg.host_chop;
      r_d.test_act      = (r_d.state == ST_ACQ) && r_d.test;
   end

   // =========================================================
   // registers
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         r_q <= '{state: ST_IDLE, sel: SEL_NONE, result: RES_RESET,
                  default: '0};
      end else begin
         r_q <= r_d;
      end
   end

   // every output is a flop field
   assign ana                = r_q.ana;
   assign diagnostic_result  = r_q.result;
   assign die_overtemp_alert = r_q.alert;
   assign result_ready       = r_q.done;
   assign test_path_active   = r_q.test_act;

   // =========================================================
   // checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);

   sequence s_diagnostic_result(logic [2:0] code);
      (r_q.state == ST_ACQ) && diagnostic_result_phase && (r_q.sel == code);
   endsequence

   sequence s_done_with_data;
      r_q.done && r_q.stage_ok;
   endsequence

   a_amp_bipolar: assert property (
      s_diagnostic_result(SEL_AMP) |=> ana.bipolar && ana.amp_short)
      else $error("amplifier diagnostic not bipolar or not shorted");

   a_amp_no_chop: assert property (
      s_diagnostic_result(SEL_AMP) |=> !ana.chop)
      else $error("chopping left on in amplifier diagnostic");

   a_zero_bipolar: assert property (
      s_diagnostic_result(SEL_ZERO) |=> ana.bipolar && ana.src == SEL_ZERO)
      else $error("zero-scale not bipolar on negative supply");

   a_supply_ref: assert property (
      s_diagnostic_result(SEL_SUPPLY) |=> ana.ref_thrm && !ana.amp_short)
      else $error("supply diagnostic reference not switched");

   a_no_diagnostic_result_code: assert property (
      (r_q.sel == SEL_NONE || r_q.sel == SEL_RSVD)
      |=> ana.src == SEL_NONE && !ana.ref_thrm && !ana.amp_short)
      else $error("diagnostic ran for code 0 or 7");

   // the first edge out of reset still shows the reset copy, so the
   // attempt only starts once reset was seen released
   a_restore_host: assert property (
      resetn && !diagnostic_result_phase |=> ana.bipolar == $past(cfg.host_bipolar)
                  && ana.chop == $past(cfg.host_chop))
      else $error("host polarity or chop not restored");

   a_result_place: assert property (
      s_done_with_data |-> diagnostic_result[15:2] == r_q.stage
                        && diagnostic_result[1:0] == RES_PAD)
      else $error("result not placed in bits 15:2");

   a_test_pattern: assert property (
      s_done_with_data ##0 r_q.test
      |-> diagnostic_result == {TEST_CODE, RES_PAD})
      else $error("converter test pattern missing from result");

   a_temp_alert: assert property (
      s_done_with_data ##0 (r_q.sel == SEL_TEMP && !r_q.test)
      |-> die_overtemp_alert == r_q.stage_alert)
      else $error("die alert not evaluated");

   a_done_pulse: assert property (
      (r_q.state == ST_ACQ) && acq_done |=> result_ready ##1 !result_ready)
      else $error("completion strobe wrong");

endmodule : ads_diagnostic_result_select

// ### ads_pkg.sv
package ads_pkg;

   // =========================================================
   // diagnostic select codes
   localparam logic [2:0]  SEL_NONE     = 3'h0;
   localparam logic [2:0]  SEL_ALTERNATE_REFERENCE   = 3'h1;
   localparam logic [2:0]  SEL_SUPPLY   = 3'h2;
   localparam logic [2:0]  SEL_AMP      = 3'h3;
   localparam logic [2:0]  SEL_ZERO     = 3'h4;
   localparam logic [2:0]  SEL_FULL     = 3'h5;
   localparam logic [2:0]  SEL_TEMP     = 3'h6;
   localparam logic [2:0]  SEL_RSVD     = 3'h7;

   // =========================================================
   // result layout and fixed codes
   localparam int          RES_W        = 16;
   localparam int          CODE_W       = 14;
   localparam int          RES_LSB      = 2;
   localparam logic [1:0]  RES_PAD      = 2'h0;
   localparam logic [15:0] RES_RESET    = 16'h0000;
   localparam logic [13:0] CODE_MID     = 14'h2000;
   localparam logic [13:0] CODE_ZERO    = 14'h0000;
   localparam logic [13:0] ALTERNATE_REFERENCE_MIN   = 14'h0FBE;
   localparam logic [13:0] ALTERNATE_REFERENCE_MAX   = 14'h100D;
   // known pattern pushed down the result path in converter test
   localparam logic [13:0] TEST_CODE    = 14'h1555;

   // =========================================================
   // types
   typedef enum logic [0:0] {ST_IDLE, ST_ACQ} ads_state_t;

   typedef struct packed {
      logic [2:0] sel;           // diagnostic_select_code
      logic       adc_test;      // converter_test_setting
      logic       host_bipolar;  // host polarity, 1 = bipolar
      logic       host_chop;     // host chopping enable
   } ads_cfg_t;

   typedef struct packed {
      logic [2:0] src;           // diagnostic source on the adc input
      logic       ref_thrm;      // thermistor bias as adc reference
      logic       amp_short;     // level-shift amplifier inputs shorted
      logic       bipolar;       // effective adc polarity
      logic       chop;          // effective chopping enable
   } ads_ana_t;

   typedef struct packed {
      logic        valid;
      logic [13:0] code;
   } ads_conv_t;

endpackage : ads_pkg

// ### ads_seq_model.sv
`timescale 1ns/1ps

// ====
// acquisition sequencer and converter stand-in
module ads_seq_model (
   input  wire logic              ref_clk,
   input  wire logic              resetn,
   input  wire logic              go,
   input  wire logic [13:0]       code_in,
   output logic                   acq_start,
   output logic                   diagnostic_result_phase,
   output logic                   acq_done,
   output ads_pkg::ads_conv_t     conv
);
   import ads_pkg::*;
   logic [2:0] step_q;

   // steps: 1 start, 2-3 diagnostic_result portion, 3 conversion, 6 done, wraps to idle
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn)
         step_q <= 3'h0;
      else if (step_q != 3'h0 || go)
         step_q <= step_q + 3'h1;
   end

   // one conversion per diagnostic_result portion, as the converter would hand over
   assign acq_start  = (step_q == 3'h1);
   assign diagnostic_result_phase = (step_q == 3'h2) || (step_q == 3'h3);
   assign acq_done   = (step_q == 3'h6);
   assign conv.valid = (step_q == 3'h3);
   // off the strobe the bus shows junk, so a late capture cannot look right
   assign conv.code  = conv.valid ? code_in : ~code_in;
endmodule : ads_seq_model

// ### tb_ads_diagnostic_result_select.sv
`timescale 1ns/1ps

module tb_ads_diagnostic_result_select;
   import ads_pkg::*;
   logic        ref_clk, resetn, go, die_temp_over, acq_start, diagnostic_result_phase;
   logic        acq_done, die_overtemp_alert, result_ready, test_path_active;
   logic        tpa_s;
   logic [13:0] code_in;
   logic [15:0] diagnostic_result;
   ads_cfg_t    cfg;
   ads_ana_t    ana, ana_s;
   ads_conv_t   conv;
   int          fails, checks;

   ads_diagnostic_result_select u_ads_diagnostic_result_select (.ref_clk(ref_clk), .resetn(resetn),
      .cfg(cfg), .acq_start(acq_start), .diagnostic_result_phase(diagnostic_result_phase),
      .acq_done(acq_done), .conv(conv), .die_temp_over(die_temp_over),
      .ana(ana), .diagnostic_result(diagnostic_result),
      .die_overtemp_alert(die_overtemp_alert), .result_ready(result_ready),
      .test_path_active(test_path_active));
   ads_seq_model u_ads_seq_model (.ref_clk(ref_clk), .resetn(resetn),
      .go(go), .code_in(code_in), .acq_start(acq_start),
      .diagnostic_result_phase(diagnostic_result_phase), .acq_done(acq_done), .conv(conv));

   // ====
   // helpers
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic test_done();
      $display("checks=%0d fails=%0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : test_done

   // ana is grabbed at the conversion strobe, the first of the two cycles it must be forced
   task automatic run_acq(input logic [2:0] sel, input logic tst,
                          input logic [13:0] code, input logic ovr);
      int n;
      @(posedge ref_clk);
      cfg.sel <= sel;
      cfg.adc_test <= tst;
      code_in <= code;
      die_temp_over <= ovr;
      go <= 1'b1;
      @(posedge ref_clk);
      go <= 1'b0;
      n = 0;
      while (result_ready !== 1'b1 && n < 20) begin
         @(posedge ref_clk);
         #1;
         if (conv.valid === 1'b1) begin
            ana_s = ana;
            tpa_s = test_path_active;
         end
         n++;
      end
      chk(16'(result_ready), 16'h0001);
   endtask : run_acq

   // ====
   // scenarios
   task automatic t_sweep();
      logic [13:0] c;
      logic        win;
      for (int s = 1; s < 7; s++) begin
         c = (s == 4) ? CODE_ZERO : (s == 5) ? 14'h3FFF :
             (s == 3) ? CODE_MID : (s == 1) ? ALTERNATE_REFERENCE_MIN :
             14'h1000 + 14'(s);
         run_acq(3'(s), 1'b0, c, 1'b0);
         chk(diagnostic_result, {c, RES_PAD});
         // host-side acceptance window for the reference diagnostic
         win = (diagnostic_result[15:2] >= ALTERNATE_REFERENCE_MIN) &&
               (diagnostic_result[15:2] <= ALTERNATE_REFERENCE_MAX);
         if (s == 1)
            chk(16'(win), 16'h0001);
         chk(16'(ana_s.src), 16'(s));
         chk(16'(ana_s.ref_thrm), 16'(s == 2));
         chk(16'(ana_s.amp_short), 16'(s == 3));
         chk(16'(ana_s.bipolar), 16'(s >= 3 && s <= 5));
         chk(16'(ana_s.chop), 16'(s != 3));
         chk(16'(ana.bipolar), 16'h0000);
         chk(16'(ana.chop), 16'h0001);
      end
      $display("t_sweep done");
   endtask : t_sweep

   task automatic t_none();
      logic [15:0] keep;
      keep = diagnostic_result;
      // flip the host settings so that plain pass-through is visible
      @(posedge ref_clk);
      cfg.host_bipolar <= 1'b1;
      cfg.host_chop <= 1'b0;
      for (int i = 0; i < 2; i++) begin
         run_acq(i ? SEL_RSVD : SEL_NONE, 1'b0, 14'h0ABC, 1'b0);
         chk(diagnostic_result, keep);
         chk(16'(ana_s.src), 16'h0000);
         chk(16'(ana_s.bipolar), 16'h0001);
         chk(16'(ana_s.chop), 16'h0000);
      end
      @(posedge ref_clk);
      cfg.host_bipolar <= 1'b0;
      cfg.host_chop <= 1'b1;
      $display("t_none done");
   endtask : t_none

   task automatic t_temp();
      for (int o = 1; o >= 0; o--) begin
         run_acq(SEL_TEMP, 1'b0, 14'h0777, 1'(o));
         chk(16'(die_overtemp_alert), 16'(o));
      end
      $display("t_temp done");
   endtask : t_temp

   task automatic t_test();
      run_acq(SEL_NONE, 1'b1, 14'h0123, 1'b0);
      chk(diagnostic_result, {TEST_CODE, RES_PAD});
      chk(16'(tpa_s), 16'h0001);
      $display("t_test done");
   endtask : t_test

   // ====
   // clock, reset, sequence and watchdog
   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end

   initial begin
      fails = 0;
      checks = 0;
      resetn = 1'b0;
      go = 1'b0;
      die_temp_over = 1'b0;
      code_in = 14'h0000;
      cfg = '{sel: SEL_NONE, adc_test: 1'b0, host_bipolar: 1'b0,
              host_chop: 1'b1};
      repeat (10) @(posedge ref_clk);
      resetn <= 1'b1;
      t_sweep();
      t_none();
      t_temp();
      t_test();
      test_done();
   end

   // 11 acquisitions of about 8 cycles; generous margin
   initial begin
      #5000;
      fails++;
      test_done();
   end
endmodule : tb_ads_diagnostic_result_select
